// ===== djk_dual_jk.sv
/*
 * Dual JK storage block: two elements, one shared falling-edge clock pin and one shared
 * active-low clear. Assumes every pin is asynchronous to CLK_I and changes slower than
 * a few CLK_I periods, so pin edges are seen after synchronisation.
 */
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// R1: Outputs change only on falling clock edge.
// R2: Set forces Q high; clear forces low.
// R3: Set and clear act without clock edge.
// R4: Set and clear ignore clock, J, K.
// R5: Set and clear low drive both high.
// R6: Releasing both together gives undefined state.
// R7: Falling edge: hold, load 0, load 1, toggle.
// R8: Driver holds J, K stable around edge.
// R9: Two elements share clock and clear.
// R10: Outputs true and complementary except both-low.
module djk_dual_jk (
   input  wire logic                            CLK_I,
   input  wire logic                            RESET_I,
   input  wire logic [djk_pkg::ELEM_COUNT-1:0]  J_I,
   input  wire logic [djk_pkg::ELEM_COUNT-1:0]  K_I,
   input  wire logic [djk_pkg::ELEM_COUNT-1:0]  SET_N_I,
   input  wire logic                            CLEAR_N_I,
   input  wire logic                            FALLING_EDGE_CLOCK_I,
   output logic      [djk_pkg::ELEM_COUNT-1:0]  Q_O,
   output logic      [djk_pkg::ELEM_COUNT-1:0]  QN_O
);
   import djk_pkg::*;

   logic [VEC_WIDTH-1:0] pins;
   logic [VEC_WIDTH-1:0] meta_r;
   logic [VEC_WIDTH-1:0] sync_r;
   logic                 clock_prev_r;
   logic                 fall;

   assign pins = {FALLING_EDGE_CLOCK_I, CLEAR_N_I, SET_N_I, K_I, J_I};

   // All pins pass two flops together, so J and K stay aligned with the clock pin they
   // were sampled against; the driver must keep them steady across the edge. [R8]
   always_ff @(posedge CLK_I) begin
      if (RESET_I) begin
         meta_r <= PIN_RESET;
         sync_r <= PIN_RESET;
      end else begin
         meta_r <= pins;
         sync_r <= meta_r;
      end
   end

   // Edge detection reads only the second stage, never the metastable first one.
   always_ff @(posedge CLK_I) begin
      if (RESET_I) begin
         clock_prev_r <= PIN_RESET[POS_CLOCK];
      end else begin
         clock_prev_r <= sync_r[POS_CLOCK];
      end
   end

   assign fall = clock_prev_r && !sync_r[POS_CLOCK];          // [R1]

   // Each element gets its own J, K and set; clock and clear fan out to both.
   generate
      for (genvar g = 0; g < ELEM_COUNT; g++) begin : g_elem
         djk_elem_if link ();
         assign link.j       = sync_r[POS_J + g];
         assign link.k       = sync_r[POS_K + g];
         assign link.set_n   = sync_r[POS_SET_N + g];
         assign link.clear_n = sync_r[POS_CLEAR_N];             // [R9]
         assign link.fall    = fall;                            // [R9]
         djk_element u_elem (
            .CLK_I   (CLK_I),
            .RESET_I (RESET_I),
            .bus     (link.elem)
         );
         assign Q_O[g]  = link.q;
         assign QN_O[g] = link.qn;
      end
   endgenerate

   // Block-level checks, pin to output. Every pin reaches the state flops through two
   // synchroniser stages, so a pin level must stand for a few samples before the outputs
   // are bound to follow it. Shorter pulses are not promised to be seen at all, which is
   // the price of sampling asynchronous pins with a single system clock.
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (RESET_I);

   // Reset must leave every element cleared with complementary outputs.
   // This one ignores the default disable, since it watches reset itself.
   chk_reset_outputs: assert property (disable iff (1'b0) (RESET_I |=> Q_O == '0 && QN_O == '1)) // [R10]
      else $error("reset did not clear the outputs");

   // The second stage copies the first one sample later and nothing else loads it.
   // A break here would let a half-settled level reach the edge detector.
   chk_sync_second_stage: assert property (sync_r == $past(meta_r)) // [R8]
      else $error("second sync stage did not follow the first");

   // A detected fall is a single-cycle pulse, so one pin edge acts only once.
   chk_fall_one_pulse: assert property (fall |=> !fall) // [R1]
      else $error("fall pulse lasted more than one cycle");

   // A detected fall must come from a real high-to-low change on the clock pin,
   // seen two and three samples back because of the synchroniser.
   chk_fall_from_pin: assert property (fall |-> $past(FALLING_EDGE_CLOCK_I, 3)
      && !$past(FALLING_EDGE_CLOCK_I, 2)) // [R1]
      else $error("fall detected without a falling clock pin");

   // Per-element pin-level checks. Each element is watched on its own J, K and set
   // pins against the shared clear and clock pins, so a wiring swap between the two
   // elements or a lost fan-out of the shared pins shows up here.
   generate
      for (genvar e = 0; e < ELEM_COUNT; e++) begin : g_pin_chk
         logic run_e;
         logic load0_e;
         logic load1_e;
         logic tog_e;
         logic hold_e;

         // Both asynchronous controls released for this element.
         assign run_e   = SET_N_I[e] && CLEAR_N_I;
         // J/K codes qualified by released controls.
         assign load0_e = run_e && !J_I[e] && K_I[e];
         assign load1_e = run_e && J_I[e] && !K_I[e];
         assign tog_e   = run_e && J_I[e] && K_I[e];
         assign hold_e  = run_e && !J_I[e] && !K_I[e];

         // Set held for three samples wins whatever clock, J and K do.
         chk_pin_set: assert property ((!SET_N_I[e] && CLEAR_N_I)[*3]
            |=> Q_O[e] && !QN_O[e]) // [R2] [R3] [R4]
            else $error("set pin did not force the true output high");

         // Clear held for three samples wins whatever clock, J and K do.
         chk_pin_clear: assert property ((SET_N_I[e] && !CLEAR_N_I)[*3]
            |=> !Q_O[e] && QN_O[e]) // [R2] [R3] [R9]
            else $error("clear pin did not force the true output low");

         // Both controls low drive both outputs high while they stay low.
         chk_pin_both_low: assert property ((!SET_N_I[e] && !CLEAR_N_I)[*3]
            |=> Q_O[e] && QN_O[e]) // [R5]
            else $error("both controls low did not drive both outputs high");

         // Once the controls have been released a while, the outputs are complementary.
         chk_pin_compl: assert property (run_e[*3] |=> QN_O[e] == !Q_O[e]) // [R10]
            else $error("outputs not complementary after release");

         // A clock pin that stays high changes nothing; the cycles around its rising edge are not checked.
         chk_pin_steady_high: assert property ((run_e && FALLING_EDGE_CLOCK_I)[*4]
            |=> $stable(Q_O[e])) // [R1]
            else $error("state changed while the clock pin stayed high");

         // A clock pin that stays low changes nothing either.
         chk_pin_steady_low: assert property ((run_e && !FALLING_EDGE_CLOCK_I)[*4]
            |=> $stable(Q_O[e])) // [R1]
            else $error("state changed while the clock pin stayed low");

         // J low, K high across a fall loads zero.
         chk_pin_load_zero: assert property ((load0_e && FALLING_EDGE_CLOCK_I) ##1
            (load0_e && !FALLING_EDGE_CLOCK_I) ##1 load0_e
            |=> ##1 (!Q_O[e] && QN_O[e])) // [R7]
            else $error("pin fall with J low K high did not load zero");

         // J high, K low across a fall loads one.
         chk_pin_load_one: assert property ((load1_e && FALLING_EDGE_CLOCK_I) ##1
            (load1_e && !FALLING_EDGE_CLOCK_I) ##1 load1_e
            |=> ##1 (Q_O[e] && !QN_O[e])) // [R7]
            else $error("pin fall with J high K low did not load one");

         // J and K high across a fall toggle the prior state.
         chk_pin_toggle: assert property ((tog_e && FALLING_EDGE_CLOCK_I) ##1
            (tog_e && !FALLING_EDGE_CLOCK_I) ##1 tog_e
            |=> ##1 (Q_O[e] != $past(Q_O[e]))) // [R7]
            else $error("pin fall with J and K high did not toggle");

         // J and K low across a fall hold the prior state.
         chk_pin_hold: assert property ((hold_e && FALLING_EDGE_CLOCK_I) ##1
            (hold_e && !FALLING_EDGE_CLOCK_I) ##1 hold_e
            |=> ##1 $stable(Q_O[e])) // [R7]
            else $error("pin fall with J and K low did not hold");
      end
   endgenerate

   // The fall detector and the synchroniser feed both elements; a fault in them would
   // show in every element at once, which is why the checks above sit at this level and
   // not only inside the element, where the inputs already arrive cleaned up.
   // A limitation worth knowing: the checks assume each pin level is held for the
   // stated number of samples, matching the driving rules for setup and hold.
endmodule // djk_dual_jk
`default_nettype wire

// ===== djk_elem_if.sv
/*
 * Carrier between the top level and one storage element.
 * Assumes the top level drives synchronised levels on CLK_I.
 */
`timescale 1ns/1ps
`default_nettype none
interface djk_elem_if;
   logic j;
   logic k;
   logic set_n;
   logic clear_n;
   logic fall;
   logic q;
   logic qn;
   modport elem (input j, input k, input set_n, input clear_n, input fall, output q, output qn);
   modport ctrl (output j, output k, output set_n, output clear_n, output fall, input q, input qn);
endinterface
`default_nettype wire

// ===== djk_element.sv
/*
 * One JK storage element with asynchronous-style set and clear priority.
 * Assumes its inputs are already synchronised to CLK_I and fall is a one-cycle pulse.
 */
`timescale 1ns/1ps
`default_nettype none
module djk_element (
   input  wire logic  CLK_I,
   input  wire logic  RESET_I,
   djk_elem_if.elem   bus
);
   import djk_pkg::*;

   logic q_r;
   logic qn_r;

   assign bus.q  = q_r;
   assign bus.qn = qn_r;

   // Set and clear win over the clock and J/K; when both are released in one cycle the
   // element keeps Q high and restores QN if no fall comes in that cycle, a fixed choice for an otherwise unknown state.
   always_ff @(posedge CLK_I) begin
      if (RESET_I) begin
         q_r  <= Q_RESET;
         qn_r <= QN_RESET;
      end else if (!bus.set_n && !bus.clear_n) begin
         q_r  <= 1'h1;                                          // [R5]
         qn_r <= 1'h1;
      end else if (!bus.set_n) begin
         q_r  <= 1'h1;                                          // [R2] [R3] [R4]
         qn_r <= 1'h0;
      end else if (!bus.clear_n) begin
         q_r  <= 1'h0;                                          // [R2] [R3] [R4]
         qn_r <= 1'h1;
      end else if (bus.fall) begin
         case ({bus.j, bus.k})                                  // [R7]
            2'h1: begin
               q_r  <= 1'h0;
               qn_r <= 1'h1;
            end
            2'h2: begin
               q_r  <= 1'h1;
               qn_r <= 1'h0;
            end
            2'h3: begin
               q_r  <= ~q_r;
               qn_r <= q_r;
            end
            default: begin
               q_r  <= q_r;
               qn_r <= ~q_r;                                    // [R6] [R10]
            end
         endcase
      end else begin
         // Also the path taken when set and clear leave together. [R6]
         q_r  <= q_r;                                           // [R1]
         qn_r <= ~q_r;                                          // [R10]
      end
   end

   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (RESET_I);

   chk_set_forces_high: assert property (!bus.set_n && bus.clear_n |=> q_r && !qn_r) // [R2]
      else $error("set did not force Q high");
   chk_clear_forces_low: assert property (bus.set_n && !bus.clear_n ##1 bus.set_n && !bus.clear_n
      |=> !q_r && qn_r) // [R3]
      else $error("clear did not hold Q low");
   chk_both_low_high: assert property (!bus.set_n && !bus.clear_n |=> q_r && qn_r) // [R5]
      else $error("both low did not drive both outputs high");
   chk_no_edge_hold: assert property (bus.set_n && bus.clear_n && !bus.fall |=> q_r == $past(q_r)) // [R1]
      else $error("state changed without a falling edge");
   chk_jk_load_zero: assert property (bus.fall && bus.set_n && bus.clear_n && !bus.j && bus.k
      |=> !q_r && qn_r) // [R7]
      else $error("J low K high did not load zero");
   chk_jk_load_one: assert property (bus.fall && bus.set_n && bus.clear_n && bus.j && !bus.k
      |=> q_r && !qn_r) // [R7]
      else $error("J high K low did not load one");
   chk_jk_toggle: assert property (bus.fall && bus.set_n && bus.clear_n && bus.j && bus.k
      |=> q_r != $past(q_r)) // [R7]
      else $error("J and K high did not toggle");
   chk_outputs_compl: assert property (bus.set_n && bus.clear_n |=> qn_r == !q_r) // [R10]
      else $error("outputs not complementary");
   chk_async_ignores_jk: assert property (!bus.set_n && bus.clear_n && bus.fall ##1 !bus.set_n
      |=> q_r) // [R4]
      else $error("clock edge overrode set");
endmodule // djk_element
`default_nettype wire

// ===== djk_pin_drv.sv
/* Pin driver that stands in for the surrounding logic.
   Assumes CLK_I is the block's 200 MHz clock; pins move just after its rising edge. */
`timescale 1ns/1ps
`default_nettype none
module djk_pin_drv (
   input  wire logic       CLK_I,
   output logic      [1:0] J_O,
   output logic      [1:0] K_O,
   output logic      [1:0] SET_N_O,
   output logic            CLEAR_N_O,
   output logic            FALL_CLK_O
);
   // Idle levels: controls released, clock pin low.
   initial begin
      J_O = 2'h0;
      K_O = 2'h0;
      SET_N_O = 2'h3;
      CLEAR_N_O = 1'h1;
      FALL_CLK_O = 1'h0;
   end
   // J and K settle while the clock pin is high and stay put well past the fall.
   task automatic fall(input logic [1:0] j, input logic [1:0] k);
      @(posedge CLK_I) begin J_O <= j; K_O <= k; FALL_CLK_O <= 1'h1; end
      repeat (3) @(posedge CLK_I);
      FALL_CLK_O <= 1'h0;
      repeat (6) @(posedge CLK_I);
   endtask
   // Set and clear are never released together, so no undefined state arises.
   task automatic levels(input logic [1:0] s, input logic c);
      @(posedge CLK_I) begin SET_N_O <= s; CLEAR_N_O <= c; end
      repeat (6) @(posedge CLK_I);
   endtask
   // A lone rising edge of the clock pin, with toggle levels on J and K.
   task automatic rise();
      @(posedge CLK_I) begin J_O <= 2'h3; K_O <= 2'h3; FALL_CLK_O <= 1'h1; end
      repeat (6) @(posedge CLK_I);
   endtask
endmodule // djk_pin_drv
`default_nettype wire

// ===== djk_pkg.sv
/*
 * Shared constants for the dual JK storage block.
 * Assumes a single 200 MHz clock and a synchronous, active-high reset.
 */
package djk_pkg;
   localparam int unsigned ELEM_COUNT  = 2;
   localparam int unsigned PIN_WIDTH   = 7;
   // Bit positions inside the sampled pin vector.
   localparam int unsigned POS_J       = 0;
   localparam int unsigned POS_K       = 2;
   localparam int unsigned POS_SET_N   = 4;
   localparam int unsigned POS_CLEAR_N = 6;
   localparam int unsigned POS_CLOCK   = 7;
   localparam int unsigned VEC_WIDTH   = 8;
   // Reset values: async controls idle high, clock idle low so no false edge appears.
   localparam logic [7:0]  PIN_RESET   = 8'h70;
   localparam logic        Q_RESET     = 1'h0;
   localparam logic        QN_RESET    = 1'h1;
   // Cycles from a pin change to the outputs: two sync stages plus the state flop.
   localparam int unsigned PIN_LATENCY = 3;
endpackage

// ===== tb_dual_jk_flipflop.sv
/* Self-checking bench for the dual JK block.
   Assumes the pin driver model and the design files are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module tb_dual_jk_flipflop;
   logic       clk_i = 1'h0;
   logic       reset_i = 1'h1;
   logic [1:0] j, k, set_n, q, qn, q_exp;
   logic       clear_n, fclk;
   int         failures = 0;
   int         compares = 0;
   djk_pin_drv drv (.CLK_I(clk_i), .J_O(j), .K_O(k), .SET_N_O(set_n), .CLEAR_N_O(clear_n), .FALL_CLK_O(fclk));
   djk_dual_jk dut (.CLK_I(clk_i), .RESET_I(reset_i), .J_I(j), .K_I(k), .SET_N_I(set_n),
                    .CLEAR_N_I(clear_n), .FALLING_EDGE_CLOCK_I(fclk), .Q_O(q), .QN_O(qn));
   // Free-running 200 MHz clock.
   initial begin
      forever #2.5 clk_i = ~clk_i;
   end
   // The single comparison point: counts and reports any difference.
   task automatic compare_vals(input logic [3:0] seen, input logic [3:0] exp);
      compares++;
      if (seen !== exp) begin
         failures++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // Outputs are read at the falling edge, long after the flop has settled.
   task automatic check(input logic [3:0] exp);
      @(negedge clk_i);
      compare_vals({q, qn}, exp);
   endtask
   task automatic tally_and_finish();
      $display("compares=%0d failures=%0d", compares, failures);
      if (failures == 0 && compares > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // Every J/K code on each element, elements given different codes to show independence.
   task automatic t_jk();
      logic [1:0] jt [5] = '{2'h1, 2'h2, 2'h3, 2'h0, 2'h1};
      logic [1:0] kt [5] = '{2'h0, 2'h1, 2'h3, 2'h0, 2'h2};
      for (int i = 0; i < 5; i++) begin
         drv.fall(jt[i], kt[i]);
         q_exp = (jt[i] & ~q_exp) | (~kt[i] & q_exp);
         check({q_exp, ~q_exp});
      end
      $display("test jk done");
   endtask
   // Set, clear and both-low, with a clock fall that element 0, held set, must ignore while element 1 loads zero.
   task automatic t_async();
      drv.levels(2'h2, 1'h1);
      check({q_exp | 2'h1, ~(q_exp | 2'h1)});
      drv.fall(2'h0, 2'h3);
      check({2'h1, 2'h2});
      drv.levels(2'h3, 1'h1);
      drv.levels(2'h3, 1'h0);
      check({2'h0, 2'h3});
      drv.levels(2'h2, 1'h0);
      check({2'h1, 2'h3});
      drv.levels(2'h3, 1'h0);
      check({2'h0, 2'h3});
      drv.levels(2'h3, 1'h1);
      q_exp = 2'h0;
      $display("test async done");
   endtask
   // Watchdog against a hung run.
   initial begin
      #100us;
      failures++;
      tally_and_finish();
   end
   // Reset, then the scenarios in turn.
   initial begin
      q_exp = 2'h0;
      repeat (20) @(posedge clk_i);
      reset_i <= 1'h0;
      check({2'h0, 2'h3});
      drv.rise();
      check({2'h0, 2'h3});
      t_jk();
      t_async();
      t_jk();
      tally_and_finish();
   end
endmodule // tb_dual_jk_flipflop
`default_nettype wire
